// ===== rtl/tof_pkg.sv
// package: register map, field layout, reset values and types of the stopwatch
package tof_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_MASK       = 8'h08;
	localparam logic [7:0] ADDR_WRAP_THR   = 8'h0c;
	localparam logic [7:0] ADDR_CYC_THR    = 8'h10;
	localparam logic [7:0] ADDR_STOP_MASK  = 8'h14;
	localparam logic [7:0] ADDR_STATE      = 8'h18;
	localparam logic [7:0] ADDR_FINE_BASE  = 8'h20;
	localparam logic [7:0] ADDR_CYC_BASE   = 8'h40;
	localparam logic [7:0] ADDR_CAL_SINGLE = 8'h58;
	localparam logic [7:0] ADDR_CAL_MULTI  = 8'h5c;
	localparam logic [7:0] ADDR_UNMAPPED   = 8'hff;

	////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int START_BIT  = 0;
	localparam int MODE_BIT   = 1;
	localparam int STOPS_LSB  = 4;
	localparam int STOPS_W    = 3;
	localparam int CALP_LSB   = 8;
	localparam int CALP_W     = 6;

	// interrupt status and mask bits
	localparam int IRQ_W      = 3;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_WRAP   = 1;
	localparam int IRQ_CYC    = 2;

	////////////////////////////////////////////////////////////////////////
	// sizes and reset values
	localparam int THR_W      = 16;
	localparam int NUM_FINE   = 6;
	localparam int NUM_CYC    = 5;
	localparam logic [STOPS_W-1:0] MAX_STOPS = 3'h5;
	localparam logic [5:0] RING_WRAP = 6'h3f;
	localparam logic [CALP_W-1:0] CALP_RESET = 6'h0a;
	localparam logic [STOPS_W-1:0] STOPS_RESET = 3'h1;
	localparam logic [THR_W-1:0] WRAP_THR_RESET = 16'hffff;
	localparam logic [THR_W-1:0] CYC_THR_RESET = 16'hffff;
	localparam logic [THR_W-1:0] STOP_MASK_RESET = 16'h0000;
	localparam logic [IRQ_W-1:0] MASK_RESET = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0]
	{
		S_IDLE     = 3'b000,
		S_ARMED    = 3'b001,
		S_FRAC     = 3'b010,
		S_RUN      = 3'b011,
		S_STOPFRAC = 3'b100,
		S_CAL1     = 3'b101,
		S_CAL2     = 3'b110
	} meas_state_e;

	typedef struct packed
	{
		logic                mode2;
		logic [STOPS_W-1:0]  stops;
		logic [CALP_W-1:0]   calPeriods;
	} meas_cfg_s;

	typedef struct packed
	{
		logic [7:0] addr;
		logic       write;
		logic       pend;
	} ahb_req_s;

endpackage

// ===== rtl/tof_stopwatch_counters.sv
// stopwatch measurement core with start/stop sequencing and an AHB-Lite slave
//
// Functional notes
// RULE1 - one start edge timed to each stop
// RULE2 - reference clock runs whenever device enabled
// RULE3 - coarse counter counts ring wraps
// RULE4 - mode 2 counts whole clocks per stop
// RULE5 - wrap flag when coarse reaches threshold
// RULE6 - cycle flag when count exceeds threshold
// RULE7 - overflow aborts measurement at once
// RULE8 - cycle counter starts edge after start
// RULE9 - stops ignored before mask value reached
// RULE10 - host keeps overflow above mask value
// RULE11 - enable acts as reset of logic
// RULE12 - calibrate one period then set periods
// RULE13 - mode 1 uses ring plus coarse only
// RULE14 - mode 2 ring times start fraction only
// RULE15 - mode 2 ring times each stop fraction
// RULE16 - one to five stops, last ends
// RULE17 - start bit drives trigger, arms start
// RULE18 - after last stop interrupt, pins disarmed
// RULE19 - overflow abort interrupts and disarms pins
`timescale 1ns/10ps

module tof_stopwatch_counters
#(
	parameter int FINE_W = 24,
	parameter int CYC_W  = 24
)
(
	// clock and reset (reset is the enable pin)
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// event pins
	input  wire logic        startPin,
	input  wire logic        stopPin,
	output logic             triggerOut,
	output logic             irqOut
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	tof_pkg::ahb_req_s            req;
	tof_pkg::meas_cfg_s           cfg;
	tof_pkg::meas_state_e         state;
	logic [tof_pkg::THR_W-1:0]    wrapThr;
	logic [tof_pkg::THR_W-1:0]    cycThr;
	logic [tof_pkg::THR_W-1:0]    stopMask;
	logic [tof_pkg::IRQ_W-1:0]    status;
	logic [tof_pkg::IRQ_W-1:0]    irqMask;
	logic [tof_pkg::IRQ_W-1:0]    irqSet;
	logic [FINE_W-1:0]            fineRes [tof_pkg::NUM_FINE];
	logic [CYC_W-1:0]             cycRes [tof_pkg::NUM_CYC];
	logic [FINE_W-1:0]            calSingle;
	logic [FINE_W-1:0]            calMulti;
	logic [2:0]                   startSync;
	logic [2:0]                   stopSync;
	logic                         startLevel;
	logic                         stopLevel;
	logic                         startRise;
	logic                         stopRise;
	logic                         startReq;
	logic                         wr;
	logic [5:0]                   ringPhase;
	logic [tof_pkg::THR_W-1:0]    ringCoarse;
	logic [5:0]                   next_ringPhase;
	logic [tof_pkg::THR_W-1:0]    next_ringCoarse;
	logic [FINE_W-1:0]            fineNow;
	logic                         ringOn;
	logic                         ringClear;
	logic [CYC_W-1:0]             cycCount;
	logic [tof_pkg::STOPS_W-1:0]  stopIdx;
	logic [tof_pkg::STOPS_W-1:0]  lastStop;
	logic [tof_pkg::CALP_W-1:0]   calTimer;
	logic                         measuring;
	logic                         stopOk;
	logic                         wrapOvf;
	logic                         cycOvf;
	logic                         abort;
	logic [31:0]                  readData;

	////////////////////////////////////////////////////////////////////////
	// functions
	function automatic logic [FINE_W-1:0] fineValue
	(
		input logic [tof_pkg::THR_W-1:0] coarse,
		input logic [5:0]                phase
	);
		logic [FINE_W+7:0] total;
		total = (FINE_W+8)'(coarse) * (FINE_W+8)'(tof_pkg::RING_WRAP)
			+ (FINE_W+8)'(phase);
		return total[FINE_W-1:0];
	endfunction

	function automatic logic [tof_pkg::STOPS_W-1:0] lastIndex
	(
		input logic [tof_pkg::STOPS_W-1:0] stops
	);
		if (stops == '0)
			return '0;
		else if (stops > tof_pkg::MAX_STOPS)
			return tof_pkg::MAX_STOPS - 3'h1;
		else
			return stops - 3'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, level taken once second and third stage agree
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			startSync  <= '0;
			stopSync   <= '0;
			startLevel <= 1'b0;
			stopLevel  <= 1'b0;
		end
		else
		begin
			startSync <= {startSync[1:0], startPin};
			stopSync  <= {stopSync[1:0], stopPin};
			if (startSync[2] == startSync[1])
				startLevel <= startSync[1];
			if (stopSync[2] == stopSync[1])
				stopLevel <= stopSync[1];
		end
	end

	assign startRise = (startSync[2] == startSync[1]) && startSync[1]
		&& !startLevel;
	assign stopRise  = (stopSync[2] == stopSync[1]) && stopSync[1]
		&& !stopLevel;

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: one wait state, response always okay
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			req       <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= '0;
		end
		else
		begin
			hresp <= 1'b0;
			if (hsel && htrans[1] && hready)
			begin
				req.addr  <= (haddr[31:8] == '0 && haddr[1:0] == 2'b00)
					? haddr[7:0] : tof_pkg::ADDR_UNMAPPED;
				req.write <= hwrite;
				req.pend  <= 1'b1;
				hreadyout <= 1'b0;
			end
			else
			begin
				req.pend  <= 1'b0;
				hreadyout <= 1'b1;
			end
			if (req.pend && !req.write)
				hrdata <= readData;
		end
	end

	assign wr = req.pend && req.write;

	always_comb
	begin
		readData = '0;
		if (req.addr >= tof_pkg::ADDR_FINE_BASE
			&& req.addr < tof_pkg::ADDR_FINE_BASE + 8'h18)
			readData = 32'(fineRes[3'((req.addr
				- tof_pkg::ADDR_FINE_BASE) >> 2)]);
		else if (req.addr >= tof_pkg::ADDR_CYC_BASE
			&& req.addr < tof_pkg::ADDR_CYC_BASE + 8'h14)
			readData = 32'(cycRes[3'((req.addr
				- tof_pkg::ADDR_CYC_BASE) >> 2)]);
		else
			unique case (req.addr)
				tof_pkg::ADDR_CTRL:
				begin
					readData[tof_pkg::MODE_BIT] = cfg.mode2;
					readData[tof_pkg::STOPS_LSB +: tof_pkg::STOPS_W] = cfg.stops;
					readData[tof_pkg::CALP_LSB +: tof_pkg::CALP_W] =
						cfg.calPeriods;
				end
				tof_pkg::ADDR_STATUS:     readData = 32'(status);
				tof_pkg::ADDR_MASK:       readData = 32'(irqMask);
				tof_pkg::ADDR_WRAP_THR:   readData = 32'(wrapThr);
				tof_pkg::ADDR_CYC_THR:    readData = 32'(cycThr);
				tof_pkg::ADDR_STOP_MASK:  readData = 32'(stopMask);
				tof_pkg::ADDR_STATE:      readData = {24'h0, 1'b0, stopIdx, 1'b0,
					state};
				tof_pkg::ADDR_CAL_SINGLE: readData = 32'(calSingle);
				tof_pkg::ADDR_CAL_MULTI:  readData = 32'(calMulti);
				default:                  readData = '0;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n) // [RULE11]
		begin
			cfg.mode2      <= 1'b1;
			cfg.stops      <= tof_pkg::STOPS_RESET;
			cfg.calPeriods <= tof_pkg::CALP_RESET;
			wrapThr        <= tof_pkg::WRAP_THR_RESET;
			cycThr         <= tof_pkg::CYC_THR_RESET;
			stopMask       <= tof_pkg::STOP_MASK_RESET;
			irqMask        <= tof_pkg::MASK_RESET;
			startReq       <= 1'b0;
		end
		else
		begin
			startReq <= wr && req.addr == tof_pkg::ADDR_CTRL
				&& hwdata[tof_pkg::START_BIT];
			if (wr && req.addr == tof_pkg::ADDR_CTRL)
			begin
				cfg.mode2      <= hwdata[tof_pkg::MODE_BIT];
				cfg.stops      <= hwdata[tof_pkg::STOPS_LSB +: tof_pkg::STOPS_W];
				cfg.calPeriods <= hwdata[tof_pkg::CALP_LSB +: tof_pkg::CALP_W];
			end
			if (wr && req.addr == tof_pkg::ADDR_WRAP_THR)
				wrapThr <= hwdata[tof_pkg::THR_W-1:0];
			if (wr && req.addr == tof_pkg::ADDR_CYC_THR)
				cycThr <= hwdata[tof_pkg::THR_W-1:0];
			if (wr && req.addr == tof_pkg::ADDR_STOP_MASK)
				stopMask <= hwdata[tof_pkg::THR_W-1:0];
			if (wr && req.addr == tof_pkg::ADDR_MASK)
				irqMask <= hwdata[tof_pkg::IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ring oscillator model: one phase step per clock, wrap every 63 steps
	assign ringOn = (state == tof_pkg::S_RUN && !cfg.mode2) // [RULE13]
		|| state == tof_pkg::S_FRAC // [RULE14]
		|| state == tof_pkg::S_STOPFRAC // [RULE15]
		|| state == tof_pkg::S_CAL1 || state == tof_pkg::S_CAL2;

	always_comb
	begin
		next_ringPhase  = ringPhase;
		next_ringCoarse = ringCoarse;
		if (ringClear)
		begin
			next_ringPhase  = '0;
			next_ringCoarse = '0;
		end
		else if (ringOn)
		begin
			if (ringPhase == tof_pkg::RING_WRAP - 6'h1)
			begin
				next_ringPhase  = '0;
				next_ringCoarse = ringCoarse + 16'h1; // [RULE3]
			end
			else
				next_ringPhase = ringPhase + 6'h1;
		end
	end

	// value reached at this edge, taken before any clear of the ring
	assign fineNow = fineValue(ringCoarse, ringPhase)
		+ FINE_W'(ringOn); // [RULE3]

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ringPhase  <= '0;
			ringCoarse <= '0;
		end
		else
		begin
			ringPhase  <= next_ringPhase;
			ringCoarse <= next_ringCoarse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event decode and overflow checks
	assign measuring = state == tof_pkg::S_FRAC || state == tof_pkg::S_RUN
		|| state == tof_pkg::S_STOPFRAC;
	assign lastStop  = lastIndex(cfg.stops); // [RULE16]
	assign stopOk    = state == tof_pkg::S_RUN && stopRise
		&& cycCount >= CYC_W'(stopMask); // [RULE9]
	assign wrapOvf   = measuring && ringOn
		&& next_ringCoarse >= wrapThr; // [RULE5]
	assign cycOvf    = measuring && cfg.mode2
		&& cycCount > CYC_W'(cycThr); // [RULE6]
	assign abort     = wrapOvf || cycOvf; // [RULE7]
	assign ringClear = (state == tof_pkg::S_ARMED && startRise)
		|| (stopOk && cfg.mode2) // [RULE15]
		|| state == tof_pkg::S_CAL1 // [RULE12]
		|| (measuring && !abort && state != tof_pkg::S_FRAC
			&& ((state == tof_pkg::S_RUN && stopOk && !cfg.mode2)
			|| state == tof_pkg::S_STOPFRAC)
			&& stopIdx == lastStop);

	////////////////////////////////////////////////////////////////////////
	// clock-cycle counter, first count on the edge after start
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cycCount <= '0;
		else if (state == tof_pkg::S_ARMED && startRise)
			cycCount <= '0; // [RULE8]
		else if (measuring && cycCount != '1)
			cycCount <= cycCount + CYC_W'(1); // [RULE4]
	end

	////////////////////////////////////////////////////////////////////////
	// measurement sequencer and result capture
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state     <= tof_pkg::S_IDLE;
			stopIdx   <= '0;
			calTimer  <= '0;
			calSingle <= '0;
			calMulti  <= '0;
			for (int i = 0; i < tof_pkg::NUM_FINE; i++)
				fineRes[i] <= '0;
			for (int i = 0; i < tof_pkg::NUM_CYC; i++)
				cycRes[i] <= '0;
		end
		else if (abort)
			state <= tof_pkg::S_IDLE; // [RULE7] [RULE19]
		else
			unique case (state)
				tof_pkg::S_IDLE:
					if (startReq)
						state <= tof_pkg::S_ARMED; // [RULE17]
				tof_pkg::S_ARMED:
					if (startRise)
					begin
						stopIdx <= '0;
						state   <= cfg.mode2 ? tof_pkg::S_FRAC
							: tof_pkg::S_RUN; // [RULE1]
					end
				tof_pkg::S_FRAC:
				begin
					fineRes[0] <= fineNow; // [RULE14]
					state      <= tof_pkg::S_RUN;
				end
				tof_pkg::S_RUN:
					if (stopOk)
					begin
						if (cfg.mode2)
						begin
							cycRes[stopIdx] <= cycCount; // [RULE4]
							state <= tof_pkg::S_STOPFRAC;
						end
						else
						begin
							fineRes[stopIdx] <= fineNow; // [RULE13] [RULE1]
							stopIdx <= stopIdx + 3'h1;
							if (stopIdx == lastStop)
								state <= tof_pkg::S_CAL1; // [RULE16]
						end
					end
				tof_pkg::S_STOPFRAC:
				begin
					fineRes[3'(stopIdx + 3'h1)] <= fineNow; // [RULE15]
					stopIdx <= stopIdx + 3'h1;
					state   <= (stopIdx == lastStop) ? tof_pkg::S_CAL1
						: tof_pkg::S_RUN; // [RULE16]
				end
				tof_pkg::S_CAL1:
				begin
					calSingle <= fineNow; // [RULE12]
					calTimer  <= 6'h1;
					state     <= tof_pkg::S_CAL2;
				end
				tof_pkg::S_CAL2:
					if (calTimer >= cfg.calPeriods)
					begin
						calMulti <= fineNow; // [RULE12]
						state    <= tof_pkg::S_IDLE;
					end
					else
						calTimer <= calTimer + 6'h1;
				default:
					state <= tof_pkg::S_IDLE;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	// trigger pin: raised by start request, dropped by start or abort
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			triggerOut <= 1'b0;
		else if (abort || (state == tof_pkg::S_ARMED && startRise))
			triggerOut <= 1'b0; // [RULE17]
		else if (state == tof_pkg::S_IDLE && startReq)
			triggerOut <= 1'b1; // [RULE17]
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status, write one to clear, set wins; masked level interrupt
	always_comb
	begin
		irqSet = '0;
		irqSet[tof_pkg::IRQ_DONE] = state == tof_pkg::S_CAL2 && !abort
			&& calTimer >= cfg.calPeriods; // [RULE18]
		irqSet[tof_pkg::IRQ_WRAP] = wrapOvf; // [RULE5]
		irqSet[tof_pkg::IRQ_CYC]  = cycOvf; // [RULE6]
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			status <= '0;
			irqOut <= 1'b0;
		end
		else
		begin
			status <= (status & ~((wr && req.addr == tof_pkg::ADDR_STATUS)
				? hwdata[tof_pkg::IRQ_W-1:0] : '0)) | irqSet;
			irqOut <= |(status & irqMask); // [RULE18] [RULE19]
		end
	end

endmodule

// ===== testbench/tof_front_end.sv
// partner: front end answering the trigger with start and stop pulses
`timescale 1ns/10ps
module tof_front_end
(
	// trigger from the stopwatch
	input wire logic trigger,
	// timing set by the bench, in ns
	input int        startLag,
	input int        nStops,
	input int        stopAt0,
	input int        stopAt1,
	// event pins
	output logic     startPin,
	output logic     stopPin
);
	initial
	begin
		startPin = 1'b0;
		stopPin = 1'b0;
	end

	// stop times are taken from the start rise
	always @(posedge trigger)
	begin
		#(startLag) startPin = 1'b1;
		#50 startPin = 1'b0;
		if (nStops > 0)
		begin
			#(stopAt0 - 50) stopPin = 1'b1;
			#50 stopPin = 1'b0;
		end
		if (nStops > 1)
		begin
			#(stopAt1 - stopAt0 - 50) stopPin = 1'b1;
			#50 stopPin = 1'b0;
		end
	end
endmodule

// ===== testbench/tof_stopwatch_chk.sv
// checker: bus handshake, reset, trigger and interrupt relations
`timescale 1ns/10ps
module tof_stopwatch_chk
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// ahb-lite slave
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// event pins
	input wire logic        startPin,
	input wire logic        stopPin,
	input wire logic        triggerOut,
	input wire logic        irqOut
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// bus handshake
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	AST_ONE_WAIT: assert property (hsel && htrans[1] && hready
		|=> !hreadyout ##1 hreadyout)
		else $error("wait state count wrong");
	AST_WAIT_CAUSE: assert property ($fell(hreadyout)
		|-> $past(hsel && htrans[1] && hready))
		else $error("wait state without a transfer");
	AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout)
		|-> $stable(hrdata))
		else $error("read data changed outside a data phase");

	////////////////////////////////////////////////////////////////////////
	// reset, trigger and interrupt
	AST_RESET: assert property (disable iff (1'b0) !rst_n
		|=> hreadyout && !triggerOut && !irqOut && hrdata == 32'h0)
		else $error("outputs not at reset values");
	AST_TRIG_DROP: assert property (triggerOut && $rose(startPin)
		|-> ##[1:6] !triggerOut)
		else $error("trigger kept after start edge");
	AST_TRIG_CAUSE: assert property ($rose(triggerOut)
		|-> $past(!hreadyout, 2) || $past(!hreadyout, 3)
		|| $past(!hreadyout, 4))
		else $error("trigger without a bus write");
	AST_IRQ_QUIET: assert property ($rose(irqOut) |-> !triggerOut)
		else $error("interrupt while trigger high");
endmodule

// ===== testbench/tof_stopwatch_counters_bench.sv
// bench: bus tasks, measurement runs and a read scoreboard
`timescale 1ns/10ps
module tof_stopwatch_counters_bench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, startPin, stopPin, triggerOut, irqOut;
	int          startLag = 105, nStops = 0, stopAt0 = 0, stopAt1 = 0;
	int          n_fail = 0, n_compared = 0, mT;
	logic [31:0] expQ[$], mE;
	int          tolQ[$];
	logic        dphRead = 1'b0;
	logic [15:0] seed = 16'hc7bb;
	logic [5:0]  calp;

	always #10 core_clk = ~core_clk;
	assign hready = hreadyout;

	tof_stopwatch_counters dut (.core_clk, .rst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.startPin, .stopPin, .triggerOut, .irqOut);
	tof_front_end fe (.trigger(triggerOut), .startLag, .nStops, .stopAt0,
		.stopAt1, .startPin, .stopPin);

	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task report_and_stop;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function logic [31:0] ctrlv(input logic m, input logic [2:0] s);
		ctrlv = {18'h0, calp, 1'b0, s, 2'h0, m, 1'b1};
	endfunction

	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge core_clk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (!hreadyout);
	endtask

	// expected read value with a tolerance, taken by the monitor
	task rd(input logic [7:0] a, input logic [31:0] e, input int t);
		expQ.push_back(e);
		tolQ.push_back(t);
		xfer(a, 1'b0, 32'h0);
	endtask

	always @(posedge core_clk)
	begin
		if (dphRead && hreadyout)
		begin
			mE = expQ.pop_front();
			mT = tolQ.pop_front();
			check((hrdata - mE <= mT || mE - hrdata <= mT) ? mE : hrdata, mE);
		end
		if (hreadyout)
			dphRead <= hsel && htrans[1] && !hwrite;
	end

	task run(input logic [31:0] c, input int n, input int s0, input int s1,
		input logic [2:0] st);
		int i;
		nStops = n;
		stopAt0 = s0;
		stopAt1 = s1;
		xfer(tof_pkg::ADDR_CTRL, 1'b1, c);
		for (i = 0; i < 10 && triggerOut !== 1'b1; i++)
			@(negedge core_clk);
		check({31'h0, triggerOut}, 32'h1);
		for (i = 0; i < 3000 && irqOut !== 1'b1; i++)
			@(negedge core_clk);
		check({31'h0, irqOut}, 32'h1);
		check({31'h0, triggerOut}, 32'h0);
		rd(tof_pkg::ADDR_STATUS, {29'h0, st}, 0);
		xfer(tof_pkg::ADDR_STATUS, 1'b1, 32'h7);
		@(negedge core_clk);
		check({31'h0, irqOut}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		rd(tof_pkg::ADDR_CTRL, 32'h0a12, 0);
		rd(tof_pkg::ADDR_MASK, 32'h7, 0);
		rd(tof_pkg::ADDR_WRAP_THR, 32'hffff, 0);
		rd(tof_pkg::ADDR_CYC_THR, 32'hffff, 0);
		rd(tof_pkg::ADDR_STOP_MASK, 32'h0, 0);
		xfer(tof_pkg::ADDR_UNMAPPED, 1'b1, 32'hffffffff);
		rd(tof_pkg::ADDR_UNMAPPED, 32'h0, 0);
		seed = lfsr(seed);
		calp = {2'h0, seed[3:0]} + 6'h2;
		xfer(tof_pkg::ADDR_STOP_MASK, 1'b1, {16'h0, seed});
		rd(tof_pkg::ADDR_STOP_MASK, {16'h0, seed}, 0);
		// mode 2: first stop inside the mask window, second accepted
		xfer(tof_pkg::ADDR_STOP_MASK, 1'b1, 32'h14);
		xfer(tof_pkg::ADDR_CYC_THR, 1'b1, 32'h3e8);
		run(ctrlv(1'b1, 3'h1), 2, 200, 1000, 3'h1);
		rd(tof_pkg::ADDR_CYC_BASE, 32'd50, 2);
		rd(tof_pkg::ADDR_FINE_BASE, 32'h1, 0);
		rd(tof_pkg::ADDR_FINE_BASE + 8'h4, 32'h1, 0);
		rd(tof_pkg::ADDR_CAL_SINGLE, 32'h1, 0);
		rd(tof_pkg::ADDR_CAL_MULTI, {26'h0, calp}, 0);
		// mode 1 with two stops
		xfer(tof_pkg::ADDR_STOP_MASK, 1'b1, 32'h0);
		run(ctrlv(1'b0, 3'h2), 2, 200, 600, 3'h1);
		rd(tof_pkg::ADDR_FINE_BASE, 32'd10, 2);
		rd(tof_pkg::ADDR_FINE_BASE + 8'h4, 32'd30, 2);
		rd(tof_pkg::ADDR_STATE, 32'h20, 0);
		// masked cycle overflow, then unmask and clear
		xfer(tof_pkg::ADDR_MASK, 1'b1, 32'h0);
		xfer(tof_pkg::ADDR_CYC_THR, 1'b1, 32'd30);
		nStops = 0;
		xfer(tof_pkg::ADDR_CTRL, 1'b1, ctrlv(1'b1, 3'h1));
		repeat (100) @(negedge core_clk);
		check({31'h0, irqOut}, 32'h0);
		rd(tof_pkg::ADDR_STATUS, 32'h4, 0);
		xfer(tof_pkg::ADDR_MASK, 1'b1, 32'h7);
		@(negedge core_clk);
		check({31'h0, irqOut}, 32'h1);
		xfer(tof_pkg::ADDR_STATUS, 1'b1, 32'h7);
		@(negedge core_clk);
		check({31'h0, irqOut}, 32'h0);
		// coarse wrap overflow in mode 1
		xfer(tof_pkg::ADDR_WRAP_THR, 1'b1, 32'h1);
		run(ctrlv(1'b0, 3'h1), 0, 0, 0, 3'h2);
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		report_and_stop();
	end
endmodule

bind tof_stopwatch_counters tof_stopwatch_chk chk (.core_clk, .rst_n,
	.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .startPin, .stopPin, .triggerOut, .irqOut);
